// [shared/rtm_params.svh]
`ifndef RTM_PARAMS_SVH
`define RTM_PARAMS_SVH
// ----------------------------------------
// Register map and timing
// ----------------------------------------
`define RTM_STATUS_OFFSET 12'h090
`define RTM_STATUS_RESET 8'hc0
`define RTM_PRI_EN_BIT 7
`define RTM_CARD_EN_BIT 6
`define RTM_CARD_EXP_BIT 3
`define RTM_PRI_EXP_BIT 1
`define RTM_LIMIT_LOG2 15
`define RTM_LIMIT_CYCLES 32'd32768
`endif

// [shared/rtm_pkg.sv]
`default_nettype none
package rtm_pkg;
	typedef enum logic [1:0] {RTM_IDLE, RTM_WAIT, RTM_DONE} rtm_state_t;
	typedef logic [11:0] rtm_addr_t;
	typedef logic [31:0] rtm_data_t;
	typedef logic [1:0] rtm_resp_t;
endpackage
`default_nettype wire

// [rtl/rtm_retry_timeout_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rtm_params.svh"

// Function
// R01: An enabled primary counter sets the primary expiry flag when a retried master stays away for 2^15 clocks.
// R02: The card-side counter does the same for card-bus retries and sets its own separate flag.
// R03: Status bit 7 enables the primary counter and resets to 1.
// R04: Status bit 6 enables the card-side counter and resets to 1.
// R05: Status bit 3 is the card-side expiry flag, reset 0, cleared by writing 1, unchanged by writing 0.
// R06: Status bit 1 is the primary expiry flag, reset 0, cleared by writing 1, unchanged by writing 0.
// R07: Status bits 5, 4, 2 and 0 read zero and ignore writes.
// R08: The status register sits at offset 0x90 with reset value 0xc0.
// R09: A disabled counter never flags, and a returning master stops and re-arms its counter.
module rtm_retry_timeout_monitor #(
	parameter int unsigned LIMIT = `RTM_LIMIT_CYCLES
) (
	input wire logic core_clk, // 50 MHz clock
	input wire logic rst, // Async reset, high
	input wire logic priRetryIssued, // Pulse: primary master retried
	input wire logic priMasterReturned, // Pulse: primary master came back
	input wire logic cardRetryIssued, // Pulse: card master retried
	input wire logic cardMasterReturned, // Pulse: card master came back
	input wire rtm_pkg::rtm_addr_t s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire rtm_pkg::rtm_data_t s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output rtm_pkg::rtm_resp_t s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire rtm_pkg::rtm_addr_t s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output rtm_pkg::rtm_data_t s_axi_rdata, // Read data
	output rtm_pkg::rtm_resp_t s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read response ready
	output logic priExpired, // Primary expiry flag
	output logic cardExpired // Card expiry flag
);
	import rtm_pkg::*;

	localparam logic [15:0] LAST = 16'(LIMIT - 1);
	localparam rtm_addr_t STATUS_ADDR = `RTM_STATUS_OFFSET;

	// ----------------------------------------
	// Status register
	// ----------------------------------------
	logic priEn_r, cardEn_r, priExp_r, cardExp_r;
	logic priFire, cardFire;
	logic [7:0] statusView;
	assign statusView = {priEn_r, cardEn_r, 2'b00, cardExp_r, 1'b0, priExp_r, 1'b0}; // R07

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	logic awHeld_r, wHeld_r;
	rtm_addr_t awAddr_r;
	rtm_data_t wData_r;
	logic [3:0] wStrb_r;
	logic doWrite, hitWrite, wrByte0;
	assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	assign hitWrite = doWrite && (awAddr_r[11:2] == STATUS_ADDR[11:2]); // R08
	assign wrByte0 = hitWrite && wStrb_r[0];

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= '0;
			wStrb_r <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			s_axi_awready <= !awHeld_r && !s_axi_awready;
			s_axi_wready <= !wHeld_r && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (doWrite)
			begin
				s_axi_bvalid <= 1'b1;
				// Unmapped words answer SLVERR so stray software shows up
				s_axi_bresp <= hitWrite ? 2'b00 : 2'b10;
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	logic hitRead;
	assign hitRead = (s_axi_araddr[11:2] == STATUS_ADDR[11:2]); // R08

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= hitRead ? {24'h000000, statusView} : 32'h00000000;
				s_axi_rresp <= hitRead ? 2'b00 : 2'b10;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register update, set beats clear
	// ----------------------------------------
	logic priExp_nxt, cardExp_nxt;
	assign priExp_nxt = priFire || (priExp_r && !(wrByte0 && wData_r[`RTM_PRI_EXP_BIT])); // R06
	assign cardExp_nxt = cardFire || (cardExp_r && !(wrByte0 && wData_r[`RTM_CARD_EXP_BIT])); // R05

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			priEn_r <= 1'(`RTM_STATUS_RESET >> `RTM_PRI_EN_BIT); // R03
			cardEn_r <= 1'(`RTM_STATUS_RESET >> `RTM_CARD_EN_BIT); // R04
			priExp_r <= 1'b0;
			cardExp_r <= 1'b0;
		end
		else
		begin
			if (wrByte0)
			begin
				priEn_r <= wData_r[`RTM_PRI_EN_BIT]; // R03
				cardEn_r <= wData_r[`RTM_CARD_EN_BIT]; // R04
			end
			priExp_r <= priExp_nxt;
			cardExp_r <= cardExp_nxt;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			priExpired <= 1'b0;
			cardExpired <= 1'b0;
		end
		else
		begin
			priExpired <= priExp_nxt;
			cardExpired <= cardExp_nxt;
		end
	end

	// ----------------------------------------
	// Retry timers
	// ----------------------------------------
	rtm_state_t priSt_r, cardSt_r;
	logic [15:0] priCnt_r, cardCnt_r;
	assign priFire = priEn_r && priSt_r == RTM_WAIT && priCnt_r == LAST && !priMasterReturned; // R01
	assign cardFire = cardEn_r && cardSt_r == RTM_WAIT && cardCnt_r == LAST && !cardMasterReturned; // R02

	// A new retry while waiting re-arms; only one outstanding retry per side is tracked
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			priSt_r <= RTM_IDLE;
			priCnt_r <= '0;
		end
		else if (!priEn_r || priMasterReturned)
		begin
			priSt_r <= RTM_IDLE; // R09
			priCnt_r <= '0;
		end
		else
		begin
			case (priSt_r)
				RTM_IDLE: if (priRetryIssued) priSt_r <= RTM_WAIT;
				RTM_WAIT:
				begin
					priCnt_r <= priCnt_r + 16'h0001;
					// A fresh retry in the expiry cycle keeps the timer armed
					if (priFire && !priRetryIssued) priSt_r <= RTM_DONE; // R01
				end
				RTM_DONE: if (priRetryIssued) priSt_r <= RTM_WAIT;
				default: priSt_r <= RTM_IDLE;
			endcase
			if (priRetryIssued) priCnt_r <= '0;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cardSt_r <= RTM_IDLE;
			cardCnt_r <= '0;
		end
		else if (!cardEn_r || cardMasterReturned)
		begin
			cardSt_r <= RTM_IDLE; // R09
			cardCnt_r <= '0;
		end
		else
		begin
			case (cardSt_r)
				RTM_IDLE: if (cardRetryIssued) cardSt_r <= RTM_WAIT;
				RTM_WAIT:
				begin
					cardCnt_r <= cardCnt_r + 16'h0001;
					if (cardFire && !cardRetryIssued) cardSt_r <= RTM_DONE; // R02
				end
				RTM_DONE: if (cardRetryIssued) cardSt_r <= RTM_WAIT;
				default: cardSt_r <= RTM_IDLE;
			endcase
			if (cardRetryIssued) cardCnt_r <= '0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence sPriArm;
		priEn_r && priRetryIssued && !priMasterReturned;
	endsequence

	a_pri_no_early: assert property (@(posedge core_clk) disable iff (rst)
		priFire |-> $past(priCnt_r) == LAST - 16'h0001) else $error("Primary fired early"); // R01
	a_card_flag_sep: assert property (@(posedge core_clk) disable iff (rst)
		cardFire && !priFire && !priExp_r |=> !priExp_r) else $error("Card set primary flag"); // R02
	a_pri_en_gate: assert property (@(posedge core_clk) disable iff (rst)
		!priEn_r |-> !priFire) else $error("Disabled primary fired"); // R09
	a_card_en_gate: assert property (@(posedge core_clk) disable iff (rst)
		!cardEn_r |-> !cardFire) else $error("Disabled card fired"); // R09
	a_pri_clear_w1: assert property (@(posedge core_clk) disable iff (rst)
		wrByte0 && wData_r[1] && !priFire |=> !priExp_r) else $error("Primary clear failed"); // R06
	a_card_set_win: assert property (@(posedge core_clk) disable iff (rst)
		cardFire |=> cardExp_r && cardExpired) else $error("Card set lost"); // R05
	a_rsvd_zero: assert property (@(posedge core_clk) disable iff (rst)
		s_axi_rvalid |-> s_axi_rdata[5:4] == 2'b00 && !s_axi_rdata[2] && !s_axi_rdata[0])
		else $error("Reserved bit read nonzero"); // R07
	a_en_write: assert property (@(posedge core_clk) disable iff (rst)
		wrByte0 |=> priEn_r == $past(wData_r[7]) && cardEn_r == $past(wData_r[6]))
		else $error("Enable write lost"); // R03
	a_pri_arm: assert property (@(posedge core_clk) disable iff (rst)
		sPriArm |=> priSt_r == RTM_WAIT && priCnt_r == 16'h0000) else $error("Arm failed"); // R09
	a_bresp_after: assert property (@(posedge core_clk) disable iff (rst)
		doWrite |=> s_axi_bvalid) else $error("No write response"); // R08
endmodule
`default_nettype wire

// [testbench/rtm_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
module rtm_master_model (
	input wire logic core_clk, // Clock
	input wire logic rst, // Async reset, high
	input wire logic go, // Retry one request now
	input wire logic [7:0] stay, // Cycles away, 0 never returns
	output logic retryIssued, // Retry pulse
	output logic masterReturned // Return pulse
);
	logic [7:0] cnt_r;
	// Stay of 0 models a master that gives up and never comes back
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= 8'h00;
			retryIssued <= 1'b0;
			masterReturned <= 1'b0;
		end
		else
		begin
			retryIssued <= go;
			masterReturned <= (cnt_r == 8'h01);
			if (go)
				cnt_r <= stay;
			else if (cnt_r != 8'h00)
				cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule
`default_nettype wire

// [testbench/retry_timeout_monitor_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module retry_timeout_monitor_bench;
	import rtm_pkg::*;
	localparam int LIM = 8;
	localparam rtm_addr_t ST = 12'h090;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic priGo = 1'b0, cardGo = 1'b0;
	logic [7:0] priStay = 8'h00, cardStay = 8'h00;
	logic priRetry, priBack, cardRetry, cardBack, priExp, cardExp;
	rtm_addr_t awaddr = 12'h000, araddr = 12'h000;
	rtm_data_t wdata = 32'h00000000, rdata, rv;
	rtm_resp_t bresp, rresp, rs;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [3:0] strb = 4'hf;
	int num_errors = 0, checks = 0, cyc = 0;
	always #10 core_clk = ~core_clk;
	rtm_master_model PRI (.core_clk(core_clk), .rst(rst), .go(priGo), .stay(priStay),
		.retryIssued(priRetry), .masterReturned(priBack));
	rtm_master_model CARD (.core_clk(core_clk), .rst(rst), .go(cardGo), .stay(cardStay),
		.retryIssued(cardRetry), .masterReturned(cardBack));
	rtm_retry_timeout_monitor #(.LIMIT(LIM)) DUT (.core_clk(core_clk), .rst(rst),
		.priRetryIssued(priRetry), .priMasterReturned(priBack),
		.cardRetryIssued(cardRetry), .cardMasterReturned(cardBack),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.priExpired(priExp), .cardExpired(cardExp));
	task end_sim;
		$display("Checks %0d, errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input rtm_addr_t a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task rd(input rtm_addr_t a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// One retry from either side, then long enough for LIM+1 edges to pass
	task retry(input logic p, input logic [7:0] s);
		priStay <= s;
		cardStay <= s;
		priGo <= p;
		cardGo <= ~p;
		@(posedge core_clk);
		priGo <= 1'b0;
		cardGo <= 1'b0;
		repeat (LIM + 4) @(posedge core_clk);
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			$display("ERROR %0t timeout", $time);
			end_sim;
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(ST);
		chk(rv, 32'h000000c0);
		rd(12'h094);
		chk({rv[29:0], rs}, 32'h00000002);
		retry(1'b1, 8'h00);
		chk({30'h0, cardExp, priExp}, 32'h00000001);
		rd(ST);
		chk(rv, 32'h000000c2);
		wr(ST, 8'h3c);
		chk({30'h0, rs}, 32'h00000000);
		rd(ST);
		chk(rv, 32'h00000002);
		wr(ST, 8'hc2);
		rd(ST);
		chk(rv, 32'h000000c0);
		retry(1'b0, 8'h00);
		chk({30'h0, cardExp, priExp}, 32'h00000002);
		wr(ST, 8'hc0);
		rd(ST);
		chk(rv, 32'h000000c8);
		wr(ST, 8'hc8);
		rd(ST);
		chk(rv, 32'h000000c0);
		retry(1'b1, 8'h03);
		retry(1'b0, 8'h03);
		chk({30'h0, cardExp, priExp}, 32'h00000000);
		wr(ST, 8'h00);
		retry(1'b1, 8'h00);
		retry(1'b0, 8'h00);
		rd(ST);
		chk(rv, 32'h00000000);
		wr(ST, 8'hc0);
		// Return in the last counted cycle still cancels; one later expires
		retry(1'b1, 8'(LIM));
		chk({30'h0, cardExp, priExp}, 32'h00000000);
		retry(1'b1, 8'(LIM + 1));
		chk({30'h0, cardExp, priExp}, 32'h00000001);
		retry(1'b0, 8'(LIM + 1));
		chk({30'h0, cardExp, priExp}, 32'h00000003);
		wr(12'h094, 8'h0a);
		chk({30'h0, rs}, 32'h00000002);
		strb <= 4'he;
		wr(ST, 8'h0a);
		strb <= 4'hf;
		rd(ST);
		chk(rv, 32'h000000ca);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(ST);
		chk({rv[29:0], rs}, 32'h00000300);
		chk({30'h0, cardExp, priExp}, 32'h00000000);
		end_sim;
	end
endmodule
`default_nettype wire
